// ---- testbench/imzs_src_model.sv ----
// Upstream baseband source model feeding I and Q samples
`timescale 1ns/1ps
module imzs_src_model
(
    input  wire logic        dataReq,
    input  wire logic [15:0] iVal,
    input  wire logic [15:0] qVal,
    output logic      [15:0] iIn,
    output logic      [15:0] qIn
);
    // Valid only in the request cycle; inverted word otherwise so a stray capture shows up
    always_comb begin
        iIn = dataReq ? iVal : ~iVal;
        qIn = dataReq ? qVal : ~qVal;
    end
endmodule : imzs_src_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the interpolating modulator top
`timescale 1ns/1ps
`include "imzs_defines.svh"
`define CHK(nm, ex, gt) begin \
    checks++; \
    if ((gt) !== (ex)) begin \
        numErrors++; \
        $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
    end \
end
module tb_top
    import imzs_pkg::*;
;
    typedef struct {
        logic [7:0]  ctrl;
        logic [15:0] iv;
        logic [15:0] qv;
        int          reqs;
    } imzs_row_type;
    // ----------------------------------------
    // Signals, design and source
    // ----------------------------------------
    logic         clk       = 1'b0;
    logic         srst      = 1'b1;
    logic [7:0]   regAddr   = 8'h00;
    logic [7:0]   regWrData = 8'h00;
    logic         regWr     = 1'b0;
    logic         regRd     = 1'b0;
    logic [15:0]  iVal      = 16'h4000;
    logic [15:0]  qVal      = 16'hC000;
    logic [7:0]   regRdData;
    logic [15:0]  iIn;
    logic [15:0]  qIn;
    logic [15:0]  iDac;
    logic [15:0]  qDac;
    logic         dataReq;
    logic [7:0]   rd;
    int           numErrors = 0;
    int           checks    = 0;
    int           reqs;
    int           seq4 [4]  = '{`IMZS_COEF_ZERO, `IMZS_COEF_ONE, `IMZS_COEF_ZERO, -`IMZS_COEF_ONE};
    int           seq8 [8]  = '{`IMZS_COEF_ZERO, `IMZS_COEF_707, `IMZS_COEF_ONE, `IMZS_COEF_707,
                                `IMZS_COEF_ZERO, -`IMZS_COEF_707, -`IMZS_COEF_ONE, -`IMZS_COEF_707};
    // Ctrl, I, Q, requests seen in 16 cycles
    imzs_row_type rows [10] = '{
        '{8'hA1, 16'h4000, 16'hC000, 4}, '{8'hF0, 16'h4000, 16'hC000, 2},
        '{8'h50, 16'h4000, 16'hC000, 8}, '{8'h00, 16'h1234, 16'hFEDC, 16},
        '{8'hA8, 16'h4000, 16'hC000, 2}, '{8'hF6, 16'h4000, 16'hC000, 2},
        '{8'hF4, 16'h4000, 16'hC000, 2}, '{8'hA6, 16'h4000, 16'hC000, 4},
        '{8'h7C, 16'h4000, 16'hC000, 4}, '{8'h18, 16'h4000, 16'hC000, 8}};

    // 20 MHz clock
    always #25 clk = ~clk;

    imzs_modulator dut (
        .clk       (clk),
        .srst      (srst),
        .regAddr   (regAddr),
        .regWrData (regWrData),
        .regWr     (regWr),
        .regRd     (regRd),
        .regRdData (regRdData),
        .iIn       (iIn),
        .qIn       (qIn),
        .dataReq   (dataReq),
        .iDac      (iDac),
        .qDac      (qDac)
    );
    imzs_src_model src (
        .dataReq (dataReq),
        .iVal    (iVal),
        .qVal    (qVal),
        .iIn     (iIn),
        .qIn     (qIn)
    );
    // ----------------------------------------
    // Reference carrier and output words
    // ----------------------------------------
    function automatic int carrier(input logic [1:0] md, input int j, input bit cosSel);
        case (md)
            2'h0: return cosSel ? `IMZS_COEF_ONE : 0;
            2'h1: return cosSel ? ((j % 2) ? -`IMZS_COEF_ONE : `IMZS_COEF_ONE) : 0;
            2'h2: return seq4[(j + (cosSel ? 1 : 0)) % 4];
            default: return seq8[(j + (cosSel ? 2 : 0)) % 8];
        endcase
    endfunction : carrier

    // Products are exact for the chosen samples, so truncation order cannot matter
    function automatic logic [15:0] expOut(input imzs_row_type rw, input int k, input bit qSide);
        int x;
        int y;
        int j;
        int co;
        int sn;
        int acc;
        x = int'($signed(rw.iv));
        y = int'($signed(rw.qv));
        j = rw.ctrl[3] ? k / 2 : k;
        co = carrier(rw.ctrl[5:4], j, 1'b1);
        sn = carrier(rw.ctrl[5:4], j, 1'b0);
        if (rw.ctrl[3] && (k % 2) == 1) begin
            return 16'h8000;
        end
        if (rw.ctrl[2]) begin
            sn = rw.ctrl[1] ? sn : -sn;
            acc = qSide ? ((x * sn) >>> 15) + ((y * co) >>> 15) : ((x * co) >>> 15) - ((y * sn) >>> 15);
        end else begin
            acc = ((qSide ? y : x) * (rw.ctrl[5] ? sn : co)) >>> 15;
        end
        acc = (acc > 32'sh7FFF) ? 32'sh7FFF : ((acc < -32'sh8000) ? -32'sh8000 : acc);
        return 16'(acc) ^ 16'h8000;
    endfunction : expOut

    // Bus cycles start right after an edge and end on the edge that takes them
    task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, output logic [7:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
        @(posedge clk);
    endtask : regRead

    task automatic summarize();
        $display("errors %0d checks %0d", numErrors, checks);
        if (numErrors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        summarize();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (1) @(posedge clk);
        #1;
        `CHK("iDac rst", 16'h8000, iDac)
        `CHK("dataReq rst", 1'b0, dataReq)
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int r = 0; r < 10; r++) begin
            iVal <= rows[r].iv;
            qVal <= rows[r].qv;
            repeat (10) @(posedge clk);
            regWrite(8'h01, rows[r].ctrl);
            repeat (2) @(posedge clk);
            reqs = 0;
            for (int k = 0; k < 16; k++) begin
                #1;
                `CHK("iDac", expOut(rows[r], k, 1'b0), iDac)
                `CHK("qDac", expOut(rows[r], k, 1'b1), qDac)
                reqs += (dataReq === 1'b1) ? 1 : 0;
                @(posedge clk);
            end
            `CHK("dataReq count", rows[r].reqs, reqs)
            regRead(8'h01, rd);
            `CHK("ctrl", rows[r].ctrl & 8'hFE, rd)
        end
        // Back-to-back write and read, then the read word drops after one cycle
        regWrite(8'h01, 8'hAD);
        regRead(8'h01, rd);
        `CHK("ctrl b2b", 8'hAC, rd)
        #1;
        `CHK("rd idle", 8'h00, regRdData)
        @(posedge clk);
        // Unmapped place is ignored and reads zero
        regWrite(8'h22, 8'hFF);
        regRead(8'h22, rd);
        `CHK("unmapped", 8'h00, rd)
        regRead(8'h01, rd);
        `CHK("ctrl kept", 8'hAC, rd)
        // Reset in mid-run returns to bypass with midscale outputs
        srst <= 1'b1;
        repeat (1) @(posedge clk);
        #1;
        `CHK("iDac rst2", 16'h8000, iDac)
        `CHK("qDac rst2", 16'h8000, qDac)
        `CHK("dataReq rst2", 1'b0, dataReq)
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        regRead(8'h01, rd);
        `CHK("ctrl rst2", 8'h00, rd)
        // Phase counts up from zero once per step since release; no stuffing
        regRead(8'h0F, rd);
        `CHK("status rst2", 8'h0A, rd)
        summarize();
    end
endmodule : tb_top

// ---- verilog/imzs_defines.svh ----
// Register offsets, field positions, reset values and fixed-point constants of the modulator block
`ifndef IMZS_DEFINES_SVH
`define IMZS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IMZS_CTRL_ADDR   8'h01
`define IMZS_STAT_ADDR   8'h0F

// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define IMZS_INTERP_MSB  7
`define IMZS_INTERP_LSB  6
`define IMZS_MOD_MSB     5
`define IMZS_MOD_LSB     4
`define IMZS_ZS_BIT      3
`define IMZS_CPLX_BIT    2
`define IMZS_SIGN_BIT    1

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define IMZS_CTRL_MASK   8'hFE
`define IMZS_CTRL_RESET  8'h00
`define IMZS_MIDSCALE    16'h8000

// ----------------------------------------------------------------------------
// Fixed-point carrier coefficients, unity at bit 15
// ----------------------------------------------------------------------------
`define IMZS_COEF_FRAC   15
`define IMZS_COEF_ONE    18'sh08000
`define IMZS_COEF_707    18'sh05A82
`define IMZS_COEF_ZERO   18'sh00000
`define IMZS_SUM_MAX     20'sh07FFF
`define IMZS_SUM_MIN     20'shF8000
`define IMZS_SMP_MAX     16'h7FFF

`endif

// ---- verilog/imzs_interp.sv ----
// Rate divider, input capture and sample-hold interpolation stage
`timescale 1ns/1ps
`include "imzs_defines.svh"
module imzs_interp
    import imzs_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  srst,
    input  wire logic  [15:0] iIn,
    input  wire logic  [15:0] qIn,
    output logic       dataReq,
    imzs_smp_if.src    smp
);

    // ------------------------------------------------------------------------
    // Divider state
    // ------------------------------------------------------------------------
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic        next_dataReq;
    logic        next_step;
    logic        next_stuff;
    logic [15:0] iHold;
    logic [15:0] qHold;
    logic [15:0] next_iHold;
    logic [15:0] next_qHold;

    // Last divider count: period minus one; period is the rate, doubled when stuffing
    function automatic logic [3:0] lastCount(input imzs_interp_type r, input logic zs);
        logic [4:0] period;
        period = 5'h01 << r;
        if (zs) begin
            period = period << 1;
        end
        return 4'(period - 5'h01);
    endfunction : lastCount

    // Next divider, request, stuff slot and held samples
    always_comb begin
        if (smp.restart || cnt == lastCount(smp.interp, smp.zsOn)) begin
            next_cnt = 4'h0;
        end else begin
            next_cnt = 4'(cnt + 4'h1);
        end
        next_dataReq = (next_cnt == 4'h0);
        next_stuff   = smp.zsOn && next_cnt[0]; // every other output slot
        next_step    = !next_stuff;
        // Zero-order hold stands in for the half-band filters
        next_iHold   = dataReq ? iIn : iHold;
        next_qHold   = dataReq ? qIn : qHold;
    end

    // Register divider and held samples
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt           <= 4'h0;
            dataReq       <= 1'b0;
            smp.step      <= 1'b0;
            smp.stuffSlot <= 1'b0;
            iHold         <= 16'h0000;
            qHold         <= 16'h0000;
        end else begin
            cnt           <= next_cnt;
            dataReq       <= next_dataReq;
            smp.step      <= next_step;
            smp.stuffSlot <= next_stuff;
            iHold         <= next_iHold;
            qHold         <= next_qHold;
        end
    end

    assign smp.iSmp = iHold;
    assign smp.qSmp = qHold;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic [3:0] gap;
    logic       seen;

    // Cycles since the last request, invalid after a restart
    always_ff @(posedge clk) begin
        if (srst || smp.restart) begin
            gap  <= 4'h0;
            seen <= 1'b0;
        end else if (dataReq) begin
            gap  <= 4'h0;
            seen <= 1'b1;
        end else begin
            gap  <= 4'(gap + 4'h1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    request_period_a: assert property (
        dataReq && seen && !smp.restart |-> gap == lastCount(smp.interp, smp.zsOn))
        else $error("input request spacing wrong for rate");

    stuff_alternate_a: assert property (
        smp.zsOn && !smp.restart && smp.stuffSlot |=> !smp.stuffSlot && smp.step)
        else $error("stuff slots not alternating");

endmodule : imzs_interp

// ---- verilog/imzs_modulator.sv ----
// Top of the interpolating modulator with complex mix and zero stuffing
// What this block does
// - Interpolation field 10 in control register 01h selects four-times interpolation.
// - Four-times real modulation multiplies filter outputs by 0, +1, 0, -1.
// - Interpolation field 11 selects eight-times interpolation.
// - Eight-times real modulation uses sine sequence 0,.707,1,.707,0,-.707,-1,-.707.
// - Control bit 3 high enables zero stuffing, low disables it.
// - Stuffing inserts one midscale sample 8000h after every interpolated sample.
// - Stuffing doubles output sample rate relative to input data rate.
// - Stuffing stage sits after the modulator, right before the converter.
// - Control bit 2 couples both channel modulators into one complex modulator.
// - Control bit 1 selects carrier exponent sign, choosing rejected sideband.
// - Modulation frequency programmable as half, quarter or eighth of the modulator sample rate, which is half the output rate when stuffing.
// - Interpolation field 00 bypasses interpolation, samples pass at input rate.
// - Field 01 interpolates by two, modulation alternates +1 and -1.
// - Bits 5 and 4 pick modulation frequency or modulation off.
// - With stuffing, data-rate divider divides by twice the interpolation rate.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "imzs_defines.svh"
module imzs_modulator
    import imzs_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  srst,
    input  wire logic  [7:0]  regAddr,
    input  wire logic  [7:0]  regWrData,
    input  wire logic  regWr,
    input  wire logic  regRd,
    output logic       [7:0]  regRdData,
    input  wire logic  [15:0] iIn,
    input  wire logic  [15:0] qIn,
    output logic       dataReq,
    output logic       [15:0] iDac,
    output logic       [15:0] qDac
);

    // ------------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------------

    // Sample times coefficient, rescaled to sample units
    function automatic logic signed [18:0] mulCoef(input logic signed [15:0] s,
                                                   input logic signed [17:0] c);
        logic signed [33:0] p;
        p = s * c;
        return p[`IMZS_COEF_FRAC+18:`IMZS_COEF_FRAC];
    endfunction : mulCoef

    // Clip a widened sum back to sixteen bits
    function automatic logic [15:0] sat16(input logic signed [19:0] x);
        logic [15:0] r;
        if (x > `IMZS_SUM_MAX) begin
            r = `IMZS_SMP_MAX;
        end else if (x < `IMZS_SUM_MIN) begin
            r = `IMZS_MIDSCALE;
        end else begin
            r = x[15:0];
        end
        return r;
    endfunction : sat16

    // Widen one product for summing
    function automatic logic signed [19:0] widen(input logic signed [18:0] a);
        return {a[18], a};
    endfunction : widen

    // Negation that clips the most negative code
    function automatic logic [15:0] neg16(input logic [15:0] x);
        // Sign bits replicated by hand: a sized cast of a concatenation pads with zeros
        return sat16(20'(-widen({{3{x[15]}}, x})));
    endfunction : neg16

    // Twos complement to offset binary for the converter
    function automatic logic [15:0] toOffset(input logic [15:0] x);
        return {~x[15], x[14:0]};
    endfunction : toOffset

    // Carrier lookup: cosine or sine term for the chosen frequency and phase
    function automatic logic signed [17:0] carrierCoef(input imzs_mod_type m,
                                                       input logic [2:0] ph,
                                                       input logic cosSel);
        logic [2:0]         idx;
        logic signed [17:0] r;
        idx = 3'h0;
        r   = `IMZS_COEF_ZERO;
        case (m)
            IMZS_MOD_FS8: begin
                idx = cosSel ? 3'(ph + 3'h2) : ph; // cosine leads by two steps
                case (idx)
                    3'h0: r = `IMZS_COEF_ZERO;
                    3'h1: r = `IMZS_COEF_707;
                    3'h2: r = `IMZS_COEF_ONE;
                    3'h3: r = `IMZS_COEF_707;
                    3'h4: r = `IMZS_COEF_ZERO;
                    3'h5: r = -`IMZS_COEF_707;
                    3'h6: r = -`IMZS_COEF_ONE;
                    default: r = -`IMZS_COEF_707;
                endcase
            end
            IMZS_MOD_FS4: begin
                idx = cosSel ? 3'({1'b0, ph[1:0]} + 3'h1) : {1'b0, ph[1:0]};
                case (idx[1:0])
                    2'h1: r = `IMZS_COEF_ONE;
                    2'h3: r = -`IMZS_COEF_ONE;
                    default: r = `IMZS_COEF_ZERO;
                endcase
            end
            IMZS_MOD_FS2: begin
                // No quadrature term exists at half rate
                r = !cosSel ? `IMZS_COEF_ZERO : (ph[0] ? -`IMZS_COEF_ONE : `IMZS_COEF_ONE);
            end
            default: begin
                r = cosSel ? `IMZS_COEF_ONE : `IMZS_COEF_ZERO;
            end
        endcase
        return r;
    endfunction : carrierCoef

    // ------------------------------------------------------------------------
    // Control register and field views
    // ------------------------------------------------------------------------
    logic [7:0]      ctrl;
    logic [7:0]      next_ctrl;
    logic            restart;
    logic            next_restart;
    logic [7:0]      next_regRdData;
    logic [2:0]      phase;
    imzs_interp_type interpSel;
    imzs_mod_type    modSel;
    logic            zsOn;
    logic            cplxOn;
    logic            signPos;

    assign interpSel = imzs_interp_type'(ctrl[`IMZS_INTERP_MSB:`IMZS_INTERP_LSB]);
    assign modSel    = imzs_mod_type'(ctrl[`IMZS_MOD_MSB:`IMZS_MOD_LSB]);
    assign zsOn      = ctrl[`IMZS_ZS_BIT];
    assign cplxOn    = ctrl[`IMZS_CPLX_BIT];
    assign signPos   = ctrl[`IMZS_SIGN_BIT];

    imzs_smp_if smp ();

    assign smp.interp  = interpSel;
    assign smp.zsOn    = zsOn;
    assign smp.restart = restart;

    // Rate divider and sample hold
    imzs_interp u_interp (
        .clk     (clk),
        .srst    (srst),
        .iIn     (iIn),
        .qIn     (qIn),
        .dataReq (dataReq),
        .smp     (smp)
    );

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------

    // Decode writes and reads; reads answer one cycle later, else zero
    always_comb begin
        next_ctrl      = ctrl;
        next_restart   = 1'b0;
        next_regRdData = 8'h00;
        if (regWr && regAddr == `IMZS_CTRL_ADDR) begin
            next_ctrl    = regWrData & `IMZS_CTRL_MASK;
            // Any change of mode restarts divider and carrier together
            next_restart = (regWrData & `IMZS_CTRL_MASK) != ctrl;
        end
        if (regRd && regAddr == `IMZS_CTRL_ADDR) begin
            next_regRdData = ctrl;
        end else if (regRd && regAddr == `IMZS_STAT_ADDR) begin
            next_regRdData = {3'h0, phase, smp.step, smp.stuffSlot};
        end else begin
            next_regRdData = 8'h00;
        end
    end

    // Register control state
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl      <= `IMZS_CTRL_RESET;
            restart   <= 1'b0;
            regRdData <= 8'h00;
        end else begin
            ctrl      <= next_ctrl;
            restart   <= next_restart;
            regRdData <= next_regRdData;
        end
    end

    // ------------------------------------------------------------------------
    // Carrier phase and mixer
    // ------------------------------------------------------------------------
    logic [2:0]         next_phase;
    logic signed [17:0] cosC;
    logic signed [17:0] sinC;
    logic signed [17:0] sinS;
    logic signed [17:0] realC;
    logic [15:0]        iMix;
    logic [15:0]        qMix;
    logic [15:0]        next_iDac;
    logic [15:0]        next_qDac;

    // Phase steps once per modulator sample, not per stuffed slot
    always_comb begin
        if (restart) begin
            next_phase = 3'h0;
        end else if (smp.step) begin
            next_phase = 3'(phase + 3'h1);
        end else begin
            next_phase = phase;
        end
    end

    // Real or complex mix, then stuffing right before the converter
    always_comb begin
        cosC  = carrierCoef(modSel, phase, 1'b1);
        sinC  = carrierCoef(modSel, phase, 1'b0);
        sinS  = signPos ? sinC : 18'(-sinC);
        realC = (modSel == IMZS_MOD_FS4 || modSel == IMZS_MOD_FS8) ? sinC : cosC;
        if (cplxOn) begin
            // Overrange is clipped rather than wrapped
            iMix = sat16(widen(mulCoef(iIsmp(), cosC)) - widen(mulCoef(qIsmp(), sinS)));
            qMix = sat16(widen(mulCoef(iIsmp(), sinS)) + widen(mulCoef(qIsmp(), cosC)));
        end else begin
            iMix = sat16(widen(mulCoef(iIsmp(), realC)));
            qMix = sat16(widen(mulCoef(qIsmp(), realC)));
        end
        if (smp.stuffSlot) begin
            next_iDac = `IMZS_MIDSCALE;
            next_qDac = `IMZS_MIDSCALE;
        end else begin
            next_iDac = toOffset(iMix);
            next_qDac = toOffset(qMix);
        end
    end

    // Held samples seen as signed
    function automatic logic signed [15:0] iIsmp();
        return smp.iSmp;
    endfunction : iIsmp

    function automatic logic signed [15:0] qIsmp();
        return smp.qSmp;
    endfunction : qIsmp

    // Register phase and converter words
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 3'h0;
            iDac  <= `IMZS_MIDSCALE;
            qDac  <= `IMZS_MIDSCALE;
        end else begin
            phase <= next_phase;
            iDac  <= next_iDac;
            qDac  <= next_qDac;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    stuff_midscale_a: assert property (
        smp.stuffSlot |=> iDac == `IMZS_MIDSCALE && qDac == `IMZS_MIDSCALE)
        else $error("stuffed slot not midscale");

    stuff_off_a: assert property (
        !zsOn && !restart |=> smp.step && !smp.stuffSlot)
        else $error("stuff slot while stuffing disabled");

    mod_bypass_a: assert property (
        smp.step && modSel == IMZS_MOD_OFF && !cplxOn |=> iDac == toOffset($past(smp.iSmp)))
        else $error("unmodulated path altered sample");

    quarter_zero_a: assert property (
        smp.step && modSel == IMZS_MOD_FS4 && !cplxOn && !phase[0] |=> iDac == `IMZS_MIDSCALE)
        else $error("quarter-rate zero step not zero");

    half_negate_a: assert property (
        smp.step && modSel == IMZS_MOD_FS2 && !cplxOn && phase[0]
        |=> iDac == toOffset(neg16($past(smp.iSmp))))
        else $error("half-rate odd step not negated");

    eighth_trough_a: assert property (
        smp.step && modSel == IMZS_MOD_FS8 && !cplxOn && phase == 3'h6
        |=> qDac == toOffset(neg16($past(smp.qSmp))))
        else $error("eighth-rate trough not minus one");

    complex_pos_a: assert property (
        smp.step && cplxOn && modSel == IMZS_MOD_FS4 && signPos && phase[1:0] == 2'h1
        |=> iDac == toOffset(neg16($past(smp.qSmp))) && qDac == toOffset($past(smp.iSmp)))
        else $error("positive complex mix wrong");

    complex_neg_a: assert property (
        smp.step && cplxOn && modSel == IMZS_MOD_FS4 && !signPos && phase[1:0] == 2'h1
        |=> iDac == toOffset($past(smp.qSmp)) && qDac == toOffset(neg16($past(smp.iSmp))))
        else $error("negative complex mix wrong");

    phase_restart_a: assert property (
        restart |=> phase == 3'h0)
        else $error("carrier phase not restarted");

    phase_advance_a: assert property (
        !restart && !smp.step |=> $stable(phase))
        else $error("phase moved on stuffed slot");

    mode_write_a: assert property (
        regWr && regAddr == `IMZS_CTRL_ADDR |=> modSel == imzs_mod_type'($past(regWrData[5:4])))
        else $error("modulation field not written");

    cover_complex_c: cover property (smp.step && cplxOn && modSel == IMZS_MOD_FS8);
    cover_stuff8_c:  cover property (smp.stuffSlot && interpSel == IMZS_INTERP_8X);
    cover_restart_c: cover property (restart ##1 dataReq);

endmodule : imzs_modulator

// ---- verilog/imzs_pkg.sv ----
// Types shared by the modulator block files
package imzs_pkg;

    // ------------------------------------------------------------------------
    // Interpolation rate field encodings
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IMZS_INTERP_1X = 2'h0,
        IMZS_INTERP_2X = 2'h1,
        IMZS_INTERP_4X = 2'h2,
        IMZS_INTERP_8X = 2'h3
    } imzs_interp_type;

    // ------------------------------------------------------------------------
    // Modulation frequency field encodings
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IMZS_MOD_OFF = 2'h0,
        IMZS_MOD_FS2 = 2'h1,
        IMZS_MOD_FS4 = 2'h2,
        IMZS_MOD_FS8 = 2'h3
    } imzs_mod_type;

endpackage : imzs_pkg

// ---- verilog/imzs_smp_if.sv ----
// Sample and configuration carrier between the rate stage and the modulator
`timescale 1ns/1ps
interface imzs_smp_if;
    import imzs_pkg::*;

    imzs_interp_type interp;
    logic            zsOn;
    logic            restart;
    logic            step;
    logic            stuffSlot;
    logic [15:0]     iSmp;
    logic [15:0]     qSmp;

    modport src (
        input  interp,
        input  zsOn,
        input  restart,
        output step,
        output stuffSlot,
        output iSmp,
        output qSmp
    );

    modport snk (
        output interp,
        output zsOn,
        output restart,
        input  step,
        input  stuffSlot,
        input  iSmp,
        input  qSmp
    );

endinterface : imzs_smp_if
